/* File: logic/slave_event_routing_pkg.sv */
// Register map, field layout and reset values of the slave event routing block
package slave_event_routing_pkg;

	// ==========================================================
	// Register byte offsets
	localparam logic [11:0] OFS_PUB_WRITE = 12'h1E4;
	localparam logic [11:0] OFS_PUB_READ  = 12'h1E8;
	localparam logic [11:0] OFS_EVENT_TASK_SHORTCUTS    = 12'h200;
	localparam logic [11:0] OFS_IRQ_MASK  = 12'h300;
	localparam logic [11:0] OFS_STATUS    = 12'h380;

	// ==========================================================
	// Field positions and widths
	localparam int          CHAN_W        = 16;
	localparam int          PUB_EN_BIT    = 31;
	localparam int          SHORT_WR_BIT  = 13;
	localparam int          SHORT_RD_BIT  = 14;
	localparam int          NUM_EV        = 6;
	localparam int          EV_STOPPED    = 0;
	localparam int          EV_ERROR      = 1;
	localparam int          EV_RX_STARTED = 2;
	localparam int          EV_TX_STARTED = 3;
	localparam int          EV_WRITE      = 4;
	localparam int          EV_READ       = 5;

	// Word bit of each event in the enable and status layout
	localparam int          EV_BIT [NUM_EV] = '{1, 9, 19, 20, 25, 26};

	// Implemented bits; all others read as zero
	localparam logic [31:0] PUB_IMPL      = 32'h8000FFFF;
	localparam logic [31:0] EVENT_TASK_SHORTCUTS_IMPL   = 32'h00006000;
	localparam logic [31:0] IRQ_MASK_IMPL = 32'h06180202;

	// ==========================================================
	// Values after reset
	localparam logic [31:0] RST_WORD      = 32'h00000000;

	// ==========================================================
	// Byte-lane write merge, restricted to implemented bits
	function automatic logic [31:0] byte_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] sel, input logic [31:0] impl);
		logic [31:0] res;
		res = old_v;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				res[8*b +: 8] = new_v[8*b +: 8];
			end
		end
		return res & impl;
	endfunction : byte_merge

	// Spread per-event flags onto the word layout
	function automatic logic [31:0] ev_to_word(input logic [NUM_EV-1:0] ev);
		logic [31:0] w;
		w = 32'h00000000;
		for (int i = 0; i < NUM_EV; i++) begin
			w[EV_BIT[i]] = ev[i];
		end
		return w;
	endfunction : ev_to_word

	// Gather per-event flags from the word layout
	function automatic logic [NUM_EV-1:0] word_to_ev(input logic [31:0] w);
		logic [NUM_EV-1:0] ev;
		ev = '0;
		for (int i = 0; i < NUM_EV; i++) begin
			ev[i] = w[EV_BIT[i]];
		end
		return ev;
	endfunction : word_to_ev

endpackage : slave_event_routing_pkg

/* File: logic/event_publish_gate.sv */
// Gate that forwards one event onto an interconnect channel when enabled
`timescale 1ns/1ps
`default_nettype none
module event_publish_gate
	import slave_event_routing_pkg::*;
#(
	parameter int CH_W = CHAN_W
) (
	// Clock and reset
	input  wire logic            clk_i,
	input  wire logic            rst_i,
	// Event and configuration
	input  wire logic            event_i,
	input  wire logic            enable_i,
	input  wire logic [CH_W-1:0] chan_i,
	// Published event
	output logic                 publish_o,
	output logic      [CH_W-1:0] chan_o
);

	// ==========================================================
	// Elaboration checks
	if (CH_W < 1) begin : g_bad_width
		$error("CH_W must be at least one");
	end

	typedef struct packed {
		logic            publish;
		logic [CH_W-1:0] chan;
	} gate_t;

	gate_t st_ff;
	gate_t nxt_st;

	// Pulse follows the event by one cycle; the channel stands until the next publish
	always_comb begin
		nxt_st         = st_ff;
		nxt_st.publish = event_i & enable_i;
		if (event_i && enable_i) begin
			nxt_st.chan = chan_i;
		end
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign publish_o = st_ff.publish;
	assign chan_o    = st_ff.chan;

endmodule : event_publish_gate
`default_nettype wire

/* File: logic/event_irq_collect.sv */
// Sticky event status with read clear and masked interrupt request
`timescale 1ns/1ps
`default_nettype none
module event_irq_collect
	import slave_event_routing_pkg::*;
#(
	parameter int N = NUM_EV
) (
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	// Events, mask and clear
	input  wire logic [N-1:0] event_i,
	input  wire logic [N-1:0] mask_i,
	input  wire logic         clear_i,
	// Status and request
	output logic      [N-1:0] status_o,
	output logic              irq_o
);

	// ==========================================================
	// Elaboration checks
	if (N < 1) begin : g_bad_count
		$error("N must be at least one");
	end

	typedef struct packed {
		logic [N-1:0] status;
	} irq_t;

	irq_t st_ff;
	irq_t nxt_st;

	// A new event beats a clear in the same cycle so it is never lost
	always_comb begin
		nxt_st        = st_ff;
		nxt_st.status = (clear_i ? '0 : st_ff.status) | event_i;
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign status_o = st_ff.status;
	assign irq_o    = |(st_ff.status & mask_i);

endmodule : event_irq_collect
`default_nettype wire

/* File: logic/slave_event_routing.sv */
// Register bank routing slave events to publish channels, shortcuts and interrupt
// Notes on behaviour
// - Write-event publish register holds the channel the write event goes to.
// - Its enable bit at one forwards the write event; at zero it is suppressed.
// - A separate read-event publish register selects the read event's channel.
// - Write-to-suspend shortcut at one fires suspend on each write event.
// - Read-to-suspend shortcut at one fires suspend on each read event.
// - Stopped event raises the interrupt only while its enable bit is one.
// - Error event raises the interrupt only while its enable bit is one.
// - Receive-started event raises the interrupt only while enabled.
// - Transmit-started event raises the interrupt only while enabled.
// - Write-command event raises the interrupt only while enabled.
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module slave_event_routing
	import slave_event_routing_pkg::*;
#(
	parameter int CH_W = CHAN_W
) (
	// Clock and reset
	input  wire logic            clk_i,
	input  wire logic            rst_i,
	// Wishbone classic slave
	input  wire logic            cyc_i,
	input  wire logic            stb_i,
	input  wire logic            we_i,
	input  wire logic [11:0]     adr_i,
	input  wire logic [3:0]      sel_i,
	input  wire logic [31:0]     dat_i,
	output logic      [31:0]     dat_o,
	output logic                 ack_o,
	// Events from the protocol engine, one-cycle pulses
	input  wire logic            stopped_i,
	input  wire logic            error_i,
	input  wire logic            receive_sequence_started_i,
	input  wire logic            transmit_sequence_started_i,
	input  wire logic            write_cmd_i,
	input  wire logic            read_cmd_i,
	// Interconnect publishing
	output logic                 write_publish_o,
	output logic      [CH_W-1:0] write_channel_index_o,
	output logic                 read_publish_o,
	output logic      [CH_W-1:0] read_channel_index_o,
	// Task trigger and interrupt
	output logic                 suspend_o,
	output logic                 irq_o
);

	// ==========================================================
	// Elaboration checks
	if (CH_W < 1 || CH_W > CHAN_W) begin : g_bad_width
		$error("CH_W must lie between 1 and the channel field width");
	end

	// ==========================================================
	// State
	typedef struct packed {
		logic        ack;
		logic [31:0] rdata;
		logic [31:0] pub_write;
		logic [31:0] pub_read;
		logic [31:0] event_task_shortcuts;
		logic [31:0] irq_mask;
		logic        suspend;
	} bank_t;

	bank_t st_ff;
	bank_t nxt_st;

	logic              req;
	logic              hit_pub_write;
	logic              hit_pub_read;
	logic              hit_event_task_shortcuts;
	logic              hit_irq_mask;
	logic              hit_status;
	logic              status_clear;
	logic [NUM_EV-1:0] ev_vec;
	logic [NUM_EV-1:0] ev_status;
	logic [NUM_EV-1:0] ev_mask;
	logic              mask_write;
	logic              hit_mapped;

	// ==========================================================
	// Bus decode
	// A request is taken only while no answer is pending, so each access acks once
	assign req           = cyc_i & stb_i & ~st_ff.ack;
	assign hit_pub_write = adr_i[11:2] == OFS_PUB_WRITE[11:2];
	assign hit_pub_read  = adr_i[11:2] == OFS_PUB_READ[11:2];
	assign hit_event_task_shortcuts    = adr_i[11:2] == OFS_EVENT_TASK_SHORTCUTS[11:2];
	assign hit_irq_mask  = adr_i[11:2] == OFS_IRQ_MASK[11:2];
	assign hit_status    = adr_i[11:2] == OFS_STATUS[11:2];
	// Clear happens at the same edge the read data is captured
	assign status_clear  = req & ~we_i & hit_status;
	// Mask writes may lower the request on their own, so checks on it step aside
	assign mask_write    = req & we_i & hit_irq_mask;
	assign hit_mapped    = hit_pub_write | hit_pub_read | hit_event_task_shortcuts | hit_irq_mask | hit_status;

	// Events in index order
	assign ev_vec = {read_cmd_i, write_cmd_i, transmit_sequence_started_i,
		receive_sequence_started_i, error_i, stopped_i};
	assign ev_mask = word_to_ev(st_ff.irq_mask);

	// ==========================================================
	// Next-state logic
	always_comb begin
		nxt_st     = st_ff;
		nxt_st.ack = req;
		nxt_st.suspend = (write_cmd_i & st_ff.event_task_shortcuts[SHORT_WR_BIT])
			| (read_cmd_i & st_ff.event_task_shortcuts[SHORT_RD_BIT]);
		if (req && we_i) begin
			if (hit_pub_write) begin
				nxt_st.pub_write = byte_merge(st_ff.pub_write, dat_i, sel_i, PUB_IMPL);
			end
			if (hit_pub_read) begin
				nxt_st.pub_read = byte_merge(st_ff.pub_read, dat_i, sel_i, PUB_IMPL);
			end
			if (hit_event_task_shortcuts) begin
				nxt_st.event_task_shortcuts = byte_merge(st_ff.event_task_shortcuts, dat_i, sel_i, EVENT_TASK_SHORTCUTS_IMPL);
			end
			if (hit_irq_mask) begin
				nxt_st.irq_mask = byte_merge(st_ff.irq_mask, dat_i, sel_i, IRQ_MASK_IMPL);
			end
		end
		// Unmapped addresses and writes return zero; the status word is read-only
		if (req && !we_i) begin
			if (hit_pub_write) begin
				nxt_st.rdata = st_ff.pub_write;
			end else if (hit_pub_read) begin
				nxt_st.rdata = st_ff.pub_read;
			end else if (hit_event_task_shortcuts) begin
				nxt_st.rdata = st_ff.event_task_shortcuts;
			end else if (hit_irq_mask) begin
				nxt_st.rdata = st_ff.irq_mask;
			end else if (hit_status) begin
				nxt_st.rdata = ev_to_word(ev_status);
			end else begin
				nxt_st.rdata = RST_WORD;
			end
		end else if (req) begin
			nxt_st.rdata = RST_WORD;
		end
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_ff <= '{ack: 1'b0, rdata: RST_WORD, pub_write: RST_WORD,
				pub_read: RST_WORD, event_task_shortcuts: RST_WORD, irq_mask: RST_WORD,
				suspend: 1'b0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ==========================================================
	// Publish gates
	// write event publish gate
	event_publish_gate #(
		.CH_W      (CH_W)
	) u_pub_write (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.event_i   (write_cmd_i),
		.enable_i  (st_ff.pub_write[PUB_EN_BIT]),
		.chan_i    (st_ff.pub_write[CH_W-1:0]),
		.publish_o (write_publish_o),
		.chan_o    (write_channel_index_o)
	);

	event_publish_gate #(
		.CH_W      (CH_W)
	) u_pub_read (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.event_i   (read_cmd_i),
		.enable_i  (st_ff.pub_read[PUB_EN_BIT]),
		.chan_i    (st_ff.pub_read[CH_W-1:0]),
		.publish_o (read_publish_o),
		.chan_o    (read_channel_index_o)
	);

	// ==========================================================
	// Interrupt collection
	event_irq_collect #(
		.N        (NUM_EV)
	) u_irq (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.event_i  (ev_vec),
		.mask_i   (ev_mask),
		.clear_i  (status_clear),
		.status_o (ev_status),
		.irq_o    (irq_o)
	);

	// ==========================================================
	// Outputs
	assign ack_o     = st_ff.ack;
	assign dat_o     = st_ff.rdata;
	assign suspend_o = st_ff.suspend;

	// ==========================================================
	// Assertions
	default clocking cb_main @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// Bus request followed by a single ack cycle
	sequence s_req;
		cyc_i && stb_i && !ack_o;
	endsequence

	sequence s_one_ack;
		ack_o ##1 !ack_o;
	endsequence

	a_bus_ack_once: assert property (s_req |=> s_one_ack)
		else $error("ack not a single cycle after request");

	// Write publish word stored, then publish channel and enable of both events
	sequence s_wr_pubw;
		cyc_i && stb_i && !ack_o && we_i && hit_pub_write && sel_i == 4'hF;
	endsequence

	a_pubw_store: assert property (s_wr_pubw |=>
		st_ff.pub_write == ($past(dat_i) & PUB_IMPL))
		else $error("write publish word not stored");

	a_pubw_channel: assert property (
		write_publish_o |-> write_channel_index_o == $past(st_ff.pub_write[CH_W-1:0]))
		else $error("write event published on wrong channel");

	a_pubw_enable: assert property (
		write_cmd_i |=> write_publish_o == $past(st_ff.pub_write[PUB_EN_BIT]))
		else $error("write publish enable not honoured");

	a_pubr_channel: assert property (
		read_cmd_i && st_ff.pub_read[PUB_EN_BIT]
		|=> read_publish_o && read_channel_index_o == $past(st_ff.pub_read[CH_W-1:0]))
		else $error("read event not published on its channel");

	a_pubr_enable: assert property (
		read_cmd_i |=> read_publish_o == $past(st_ff.pub_read[PUB_EN_BIT]))
		else $error("read publish enable not honoured");

	// Channel outputs stand between publishes; the cycle after reset is left out
	a_pubw_hold: assert property (
		!write_publish_o && !$past(rst_i) |-> $stable(write_channel_index_o))
		else $error("write channel changed without a publish");

	a_pubr_hold: assert property (
		!read_publish_o && !$past(rst_i) |-> $stable(read_channel_index_o))
		else $error("read channel changed without a publish");

	a_wr_suspend: assert property (
		write_cmd_i && st_ff.event_task_shortcuts[SHORT_WR_BIT] |=> suspend_o)
		else $error("write shortcut did not trigger suspend");

	a_rd_suspend: assert property (
		read_cmd_i && st_ff.event_task_shortcuts[SHORT_RD_BIT] |=> suspend_o)
		else $error("read shortcut did not trigger suspend");

	a_suspend_cause: assert property (
		suspend_o |-> $past((write_cmd_i && st_ff.event_task_shortcuts[SHORT_WR_BIT])
			|| (read_cmd_i && st_ff.event_task_shortcuts[SHORT_RD_BIT])))
		else $error("suspend without an enabled shortcut");

	a_stop_irq: assert property (
		stopped_i && st_ff.irq_mask[EV_BIT[EV_STOPPED]] && !status_clear
			&& !mask_write |=> irq_o)
		else $error("stopped interrupt missing");

	a_error_irq: assert property (
		error_i && st_ff.irq_mask[EV_BIT[EV_ERROR]] && !status_clear
			&& !mask_write |=> irq_o)
		else $error("error interrupt missing");

	a_rx_irq: assert property (
		receive_sequence_started_i && st_ff.irq_mask[EV_BIT[EV_RX_STARTED]]
			&& !mask_write |=> irq_o)
		else $error("receive started interrupt missing");

	a_tx_irq: assert property (
		transmit_sequence_started_i && st_ff.irq_mask[EV_BIT[EV_TX_STARTED]]
			&& !mask_write |=> irq_o)
		else $error("transmit started interrupt missing");

	a_write_irq: assert property (
		write_cmd_i && st_ff.irq_mask[EV_BIT[EV_WRITE]] && !mask_write |=> irq_o)
		else $error("write command interrupt missing");

	a_read_irq: assert property (
		read_cmd_i && st_ff.irq_mask[EV_BIT[EV_READ]] && !mask_write |=> irq_o)
		else $error("read command interrupt missing");

	a_irq_masked: assert property (
		!irq_o && (ev_vec & ev_mask) == '0 && !mask_write |=> !irq_o)
		else $error("interrupt raised by a masked event");

	a_irq_sticky: assert property (
		irq_o && !status_clear && !mask_write |=> irq_o)
		else $error("interrupt dropped while its event stood");

	// An event and a clearing read at one edge: set wins
	sequence s_clear_hit;
		status_clear && ev_vec != '0;
	endsequence

	a_set_wins: assert property (
		s_clear_hit |=> (ev_status & $past(ev_vec)) == $past(ev_vec))
		else $error("event lost under a clearing read");

	a_status_clear: assert property (
		status_clear && ev_vec == '0 |=> ev_status == '0)
		else $error("status word not cleared by its read");

	// Bus answers only requests, and read data stands between accesses
	a_ack_idle: assert property (
		!(cyc_i && stb_i) |=> !ack_o)
		else $error("ack without a request");

	a_rdata_hold: assert property (
		!req |=> $stable(dat_o))
		else $error("read data changed without an access");

	sequence s_rd_unmapped;
		req && !we_i && !hit_mapped;
	endsequence

	a_unmapped_zero: assert property (
		s_rd_unmapped |=> ack_o && dat_o == RST_WORD)
		else $error("unmapped read did not return zero");

	sequence s_wr_mask;
		mask_write && sel_i == 4'hF;
	endsequence

	a_mask_store: assert property (
		s_wr_mask |=> st_ff.irq_mask == ($past(dat_i) & IRQ_MASK_IMPL))
		else $error("interrupt mask word not stored");

	// Must look while reset stands, so the default disable is overridden
	a_reset_clear: assert property (@(posedge clk_i) disable iff (1'b0)
		rst_i |=> st_ff.pub_write == RST_WORD && st_ff.pub_read == RST_WORD
			&& st_ff.event_task_shortcuts == RST_WORD && st_ff.irq_mask == RST_WORD && !irq_o)
		else $error("configuration not cleared by reset");

endmodule : slave_event_routing
`default_nettype wire

/* File: dv/tb.sv */
// Self-checking bench for the slave event routing register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
	import slave_event_routing_pkg::*;

	// ==========================================================
	// Signals
	logic        clk_i;
	logic        rst_i;
	logic        cyc_i;
	logic        stb_i;
	logic        we_i;
	logic [11:0] adr_i;
	logic [3:0]  sel_i;
	logic [31:0] dat_i;
	logic [31:0] dat_o;
	logic        ack_o;
	logic [5:0]  ev;
	logic        write_publish_o;
	logic [15:0] write_channel_index_o;
	logic        read_publish_o;
	logic [15:0] read_channel_index_o;
	logic        suspend_o;
	logic        irq_o;
	logic [31:0] q;
	int          bad_count;
	int          compares;

	slave_event_routing i_slave_event_routing (
		.clk_i                      (clk_i),
		.rst_i                      (rst_i),
		.cyc_i                      (cyc_i),
		.stb_i                      (stb_i),
		.we_i                       (we_i),
		.adr_i                      (adr_i),
		.sel_i                      (sel_i),
		.dat_i                      (dat_i),
		.dat_o                      (dat_o),
		.ack_o                      (ack_o),
		.stopped_i                  (ev[EV_STOPPED]),
		.error_i                    (ev[EV_ERROR]),
		.receive_sequence_started_i (ev[EV_RX_STARTED]),
		.transmit_sequence_started_i(ev[EV_TX_STARTED]),
		.write_cmd_i                (ev[EV_WRITE]),
		.read_cmd_i                 (ev[EV_READ]),
		.write_publish_o            (write_publish_o),
		.write_channel_index_o      (write_channel_index_o),
		.read_publish_o             (read_publish_o),
		.read_channel_index_o       (read_channel_index_o),
		.suspend_o                  (suspend_o),
		.irq_o                      (irq_o)
	);

	// ==========================================================
	// Clock, 50 ns period
	always #25 clk_i = ~clk_i;

	// ==========================================================
	// Bus and event tasks
	// One classic cycle; the bench never assumes when ack comes
	task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] r);
		int n;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		adr_i <= a;
		sel_i <= s;
		dat_i <= d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 50);
		r = dat_o;
		if (ack_o !== 1'b1) begin
			bad_count++;
			$display("ERROR t=%0t no ack got=%h exp=%h", $time, ack_o, 1'b1);
		end
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i  <= 1'b0;
	endtask : wb

	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] dummy;
		wb(1'b1, a, d, s, dummy);
	endtask : wr

	task automatic rd(input logic [11:0] a, output logic [31:0] r);
		wb(1'b0, a, 32'h00000000, 4'hF, r);
	endtask : rd

	// One-cycle event pulse; returns once the registered answers have settled
	task automatic pulse(input logic [5:0] v);
		@(posedge clk_i);
		ev <= v;
		@(posedge clk_i);
		ev <= 6'h00;
		#1;
	endtask : pulse

	// ==========================================================
	// Scenarios
	task automatic t_reset();
		rd(OFS_PUB_WRITE, q); `CHK(q, 32'h00000000)
		rd(OFS_PUB_READ, q);  `CHK(q, 32'h00000000)
		rd(OFS_EVENT_TASK_SHORTCUTS, q);    `CHK(q, 32'h00000000)
		rd(OFS_IRQ_MASK, q);  `CHK(q, 32'h00000000)
		wr(12'h100, 32'hFFFFFFFF, 4'hF);
		rd(12'h100, q);       `CHK(q, 32'h00000000)
		// Nothing enabled yet, so no event may leak out
		pulse(6'h3F);
		`CHK({write_publish_o, read_publish_o, suspend_o, irq_o}, 4'h0)
		rd(OFS_STATUS, q);    `CHK(q, IRQ_MASK_IMPL)
		$display("test reset done");
	endtask : t_reset

	task automatic t_publish();
		wr(OFS_PUB_WRITE, 32'hFFFFFFFF, 4'hF);
		rd(OFS_PUB_WRITE, q); `CHK(q, 32'h8000FFFF)
		wr(OFS_PUB_WRITE, 32'h00000000, 4'h8);
		rd(OFS_PUB_WRITE, q); `CHK(q, 32'h0000FFFF)
		// Channel set but enable clear: the event must stay local
		wr(OFS_PUB_WRITE, 32'h00001234, 4'hF);
		pulse(6'h01 << EV_WRITE);
		`CHK(write_publish_o, 1'b0)
		wr(OFS_PUB_WRITE, 32'h8000ABCD, 4'hF);
		wr(OFS_PUB_READ, 32'h80005A5A, 4'hF);
		rd(OFS_PUB_READ, q);  `CHK(q, 32'h80005A5A)
		pulse(6'h01 << EV_WRITE);
		`CHK({write_publish_o, read_publish_o}, 2'b10)
		`CHK(write_channel_index_o, 16'hABCD)
		pulse(6'h01 << EV_READ);
		`CHK({write_publish_o, read_publish_o}, 2'b01)
		`CHK(read_channel_index_o, 16'h5A5A)
		`CHK(write_channel_index_o, 16'hABCD)
		wr(OFS_PUB_READ, 32'h00005A5A, 4'h8);
		pulse(6'h01 << EV_READ);
		`CHK(read_publish_o, 1'b0)
		$display("test publish done");
	endtask : t_publish

	task automatic t_event_task_shortcuts();
		wr(OFS_EVENT_TASK_SHORTCUTS, 32'hFFFFFFFF, 4'hF);
		rd(OFS_EVENT_TASK_SHORTCUTS, q); `CHK(q, 32'h00006000)
		wr(OFS_EVENT_TASK_SHORTCUTS, 32'h00002000, 4'hF);
		pulse(6'h01 << EV_WRITE); `CHK(suspend_o, 1'b1)
		pulse(6'h01 << EV_READ);  `CHK(suspend_o, 1'b0)
		wr(OFS_EVENT_TASK_SHORTCUTS, 32'h00004000, 4'hF);
		pulse(6'h01 << EV_WRITE); `CHK(suspend_o, 1'b0)
		pulse(6'h01 << EV_READ);  `CHK(suspend_o, 1'b1)
		@(posedge clk_i);
		#1;
		`CHK(suspend_o, 1'b0)
		wr(OFS_EVENT_TASK_SHORTCUTS, 32'h00000000, 4'hF);
		pulse(6'h30); `CHK(suspend_o, 1'b0)
		rd(OFS_STATUS, q);
		$display("test shortcuts done");
	endtask : t_event_task_shortcuts

	// Each event alone: masked by its own bit, then let through by it
	task automatic t_irq();
		logic [31:0] b;
		for (int i = 0; i < NUM_EV; i++) begin
			b = 32'h00000001 << EV_BIT[i];
			wr(OFS_IRQ_MASK, IRQ_MASK_IMPL & ~b, 4'hF);
			pulse(6'h01 << i);
			`CHK(irq_o, 1'b0)
			rd(OFS_STATUS, q); `CHK(q, b)
			wr(OFS_IRQ_MASK, b, 4'hF);
			rd(OFS_IRQ_MASK, q); `CHK(q, b)
			`CHK(irq_o, 1'b0)
			pulse(6'h01 << i);
			`CHK(irq_o, 1'b1)
			rd(OFS_STATUS, q); `CHK(q, b)
			`CHK(irq_o, 1'b0)
		end
		$display("test interrupts done");
	endtask : t_irq

	// A clearing read and an event taken at one edge: the event must survive
	task automatic t_setwins();
		wr(OFS_IRQ_MASK, 32'h00000001 << EV_BIT[EV_ERROR], 4'hF);
		fork
			rd(OFS_STATUS, q);
			pulse(6'h01 << EV_ERROR);
		join
		`CHK(q, 32'h00000000)
		`CHK(irq_o, 1'b1)
		rd(OFS_STATUS, q); `CHK(q, 32'h00000200)
		`CHK(irq_o, 1'b0)
		$display("test clear and event done");
	endtask : t_setwins

	// Reset in mid-run with everything configured and an interrupt standing
	task automatic t_rerst();
		wr(OFS_EVENT_TASK_SHORTCUTS, 32'h00006000, 4'hF);
		pulse(6'h3F);
		`CHK({suspend_o, irq_o}, 2'b11)
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		`CHK({ack_o, suspend_o, irq_o}, 3'b000)
		t_reset();
		$display("test mid-run reset done");
	endtask : t_rerst

	// ==========================================================
	// Verdict and end of run
	task automatic close_out();
		$display("compares=%0d bad_count=%0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : close_out

	// Watchdog, far beyond the few hundred cycles the tests need
	initial begin
		#(50 * 20000);
		bad_count++;
		close_out();
	end

	// ==========================================================
	// Main sequence
	initial begin
		clk_i     = 1'b0;
		rst_i     = 1'b1;
		cyc_i     = 1'b0;
		stb_i     = 1'b0;
		we_i      = 1'b0;
		adr_i     = 12'h000;
		sel_i     = 4'h0;
		dat_i     = 32'h00000000;
		ev        = 6'h00;
		bad_count = 0;
		compares  = 0;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_publish();
		t_event_task_shortcuts();
		t_irq();
		t_setwins();
		t_rerst();
		close_out();
	end
endmodule : tb
`default_nettype wire
